/* src/pin_sync3.sv */
// Three-stage synchroniser with a stability filter for asynchronous pin levels.
// Assumes the pins change slowly compared to the core clock.
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinStable
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pinAsync;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
      pinStable <= '0;
    else
      pinStable <= (s2_q & s3_q) | (pinStable & (s2_q | s3_q));
  end

endmodule

`default_nettype wire

/* src/return_stack_exec.sv */
// Execution control: cycle phases, no-operation insertion, port and timer side
// effects, table write continuation and the hardware return stack.
// Assumes the fetch unit presents the next word on instrWord during Q4.
`timescale 1ns/100ps
`default_nettype none

module return_stack_exec #(
  parameter int STACK_DEPTH = 31,
  parameter int PC_W = 21,
  parameter int PORT_COUNT = 5,
  parameter logic [7:0] PORT_BASE = 8'h80,
  parameter logic [7:0] TIMER_ZERO_ADDR = 8'hD6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch and core inputs, same clock
  input wire logic [15:0] instrWord,
  input wire logic [PC_W-1:0] pcPlus2,
  input wire logic pcChange,
  input wire logic condTrue,
  input wire logic aluStatusWe,
  input wire logic timerPrescalerAssigned,
  // Program memory write handshake
  input wire logic tblWriteLaunch,
  input wire logic memWriteDone,
  // Port pins, asynchronous
  input wire logic [PORT_COUNT*8-1:0] portPins,
  // Outputs
  output logic [1:0] qPhase_q,
  output logic execNop_q,
  output logic consumedWord_q,
  output logic statusWe_q,
  output logic prescalerClr_q,
  output rs_exec_pkg::rmw_req_t rmw_q,
  output logic tblWriteBusy_q,
  output logic [PC_W-1:0] returnStackTop_q,
  output logic [$clog2(STACK_DEPTH+1)-1:0] stackPtr_q
);

  localparam int SP_W = $clog2(STACK_DEPTH+1);

  // Refused at elaboration: the stack and port decode need these bounds
  if (STACK_DEPTH < 2 || PORT_COUNT < 1 || PC_W < 2 || 32'(PORT_BASE) + PORT_COUNT > 256)
  begin : gBadParams
    $error("return_stack_exec: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  rs_exec_pkg::exec_state_t state_q;
  rs_exec_pkg::exec_state_t stateNext;
  logic [15:0] instr_q;
  logic [PC_W-1:0] stackMem_q [STACK_DEPTH];
  logic [PORT_COUNT*8-1:0] pinsStable;
  logic lone;
  logic exec;
  logic isPop;
  logic isPush;
  logic isTblwt;
  logic writesF;
  logic [7:0] fAddr;
  logic portHit;
  logic [7:0] portIdx;
  logic [7:0] pinByte;

  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:6] == 10'b1110111000) || (w[15:12] == 4'hC) ||
      (w[15:9] == 7'b1110110) || (w[15:8] == 8'hEF);
  endfunction

  // Lone second words decode as no-operation
  assign lone = instr_q[15:12] == rs_exec_pkg::PREFIX_SECOND_WORD;
  assign exec = (state_q == rs_exec_pkg::ST_RUN) && !lone;
  assign isPop = exec && (instr_q == rs_exec_pkg::OP_STACK_DISCARD);
  assign isPush = exec && (instr_q == rs_exec_pkg::OP_STACK_PUSH);
  assign isTblwt = exec && (instr_q[15:2] == rs_exec_pkg::OP_TBLWT_TOP);
  assign fAddr = instr_q[7:0];

  // Writes the file register: byte ops with d set, bit ops, and the d-less movers
  assign writesF = exec && !instr_q[rs_exec_pkg::ACCESS_BIT] &&
    (((instr_q[15:12] >= 4'h2) && (instr_q[15:12] <= 4'h5) &&
      instr_q[rs_exec_pkg::DEST_BIT]) ||
     (instr_q[15:12] == 4'h7) || (instr_q[15:12] == 4'h8) || (instr_q[15:12] == 4'h9) ||
     (instr_q[15:9] == 7'b0110111) || (instr_q[15:9] == 7'b0110101) ||
     (instr_q[15:9] == 7'b0110100));

  assign portHit = (fAddr >= PORT_BASE) && (32'(fAddr) < 32'(PORT_BASE) + PORT_COUNT);
  assign portIdx = fAddr - PORT_BASE;

  always_comb
  begin
    pinByte = 8'h00;
    for (int i = 0; i < PORT_COUNT; i++)
    begin
      if (portIdx == 8'(i))
        pinByte = pinsStable[i*8 +: 8];
    end
  end

  pin_sync3 #(
    .WIDTH(PORT_COUNT*8)
  ) pin_sync3_inst (
    .clk(clk),
    .rst(rst),
    .pinAsync(portPins),
    .pinStable(pinsStable)
  );

  // ---------------------------------------------------------------
  // Cycle sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    if (exec && two_word(instr_q))
      stateNext = rs_exec_pkg::ST_OPERAND;
    else if (exec && (pcChange || condTrue))
      stateNext = rs_exec_pkg::ST_FLUSH;
    else
      stateNext = rs_exec_pkg::ST_RUN;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      qPhase_q <= rs_exec_pkg::Q1;
    else
      qPhase_q <= qPhase_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= rs_exec_pkg::ST_RUN;
      instr_q <= rs_exec_pkg::RST_INSTR;
      execNop_q <= 1'b0;
      consumedWord_q <= 1'b0;
    end
    else if (qPhase_q == rs_exec_pkg::Q4)
    begin
      state_q <= stateNext;
      instr_q <= instrWord;
      // Second cycle is a bubble; a stray operand word is one too
      execNop_q <= (stateNext == rs_exec_pkg::ST_FLUSH) ||
        ((stateNext == rs_exec_pkg::ST_RUN) &&
         (instrWord[15:12] == rs_exec_pkg::PREFIX_SECOND_WORD));
      consumedWord_q <= stateNext == rs_exec_pkg::ST_OPERAND;
    end
  end

  // ---------------------------------------------------------------
  // Status, timer and port side effects
  // ---------------------------------------------------------------
  // Stack instructions never touch the flags
  always_ff @(posedge clk)
  begin
    if (rst)
      statusWe_q <= 1'b0;
    else
      statusWe_q <= (qPhase_q == rs_exec_pkg::Q4) && exec && aluStatusWe &&
        !isPop && !isPush;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prescalerClr_q <= 1'b0;
    else
      prescalerClr_q <= (qPhase_q == rs_exec_pkg::Q4) && writesF &&
        (fAddr == TIMER_ZERO_ADDR) && timerPrescalerAssigned;
  end

  // Operand is sampled at Q2 so the pin read settles before the ALU uses it
  always_ff @(posedge clk)
  begin
    if (rst)
      rmw_q <= '0;
    else if (qPhase_q == rs_exec_pkg::Q1)
      rmw_q <= '0;
    else if (qPhase_q == rs_exec_pkg::Q2 && writesF && portHit)
    begin
      rmw_q.selPins <= 1'b1;
      rmw_q.operand <= pinByte;
    end
  end

  // ---------------------------------------------------------------
  // Table write continuation
  // ---------------------------------------------------------------
  // Only the memory ends the cycle; a new launch wins over a done
  always_ff @(posedge clk)
  begin
    if (rst)
      tblWriteBusy_q <= 1'b0;
    else if (qPhase_q == rs_exec_pkg::Q4 && isTblwt && tblWriteLaunch)
      tblWriteBusy_q <= 1'b1;
    else if (memWriteDone)
      tblWriteBusy_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // Saturating: a push when full is dropped, a discard when empty yields zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      returnStackTop_q <= PC_W'(rs_exec_pkg::RST_STACK_TOP);
      stackPtr_q <= '0;
    end
    else if (qPhase_q == rs_exec_pkg::Q2 && isPush && stackPtr_q < SP_W'(STACK_DEPTH))
    begin
      stackMem_q[stackPtr_q] <= returnStackTop_q;
      returnStackTop_q <= pcPlus2;
      stackPtr_q <= stackPtr_q + 1'b1;
    end
    else if (qPhase_q == rs_exec_pkg::Q3 && isPop)
    begin
      if (stackPtr_q != '0)
      begin
        returnStackTop_q <= stackMem_q[stackPtr_q - 1'b1];
        stackPtr_q <= stackPtr_q - 1'b1;
      end
      else
        returnStackTop_q <= PC_W'(rs_exec_pkg::RST_STACK_TOP);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rmw_pins_a: assert property ((qPhase_q == rs_exec_pkg::Q2 && writesF && portHit)
    |=> rmw_q.selPins && rmw_q.operand == $past(pinByte))
    else $error("port write-back operand not taken from pins");
  tmr_clear_a: assert property ((qPhase_q == rs_exec_pkg::Q4 && writesF &&
    fAddr == TIMER_ZERO_ADDR && timerPrescalerAssigned) |=> prescalerClr_q ##1 !prescalerClr_q)
    else $error("prescaler clear pulse missing");
  flush_nop_a: assert property ((qPhase_q == rs_exec_pkg::Q4 && exec &&
    !two_word(instr_q) && (pcChange || condTrue)) |=>
    (execNop_q && !isPush && !isPop) [*4])
    else $error("branch did not insert a no-operation cycle");
  lone_word_a: assert property ((qPhase_q == rs_exec_pkg::Q4 &&
    stateNext == rs_exec_pkg::ST_RUN && instrWord[15:12] == rs_exec_pkg::PREFIX_SECOND_WORD)
    |=> execNop_q && !exec)
    else $error("lone second word executed");
  tbl_hold_a: assert property ((tblWriteBusy_q && !memWriteDone) |=> tblWriteBusy_q)
    else $error("table write ended early");
  pop_drop_a: assert property ((qPhase_q == rs_exec_pkg::Q3 && isPop &&
    stackPtr_q != '0) |=> stackPtr_q == $past(stackPtr_q) - 1'b1 ##1 !statusWe_q)
    else $error("discard did not drop top entry");
  push_top_a: assert property ((qPhase_q == rs_exec_pkg::Q2 && isPush &&
    stackPtr_q < SP_W'(STACK_DEPTH)) |=> returnStackTop_q == $past(pcPlus2) &&
    stackPtr_q == $past(stackPtr_q) + 1'b1 ##2 !statusWe_q)
    else $error("push did not store next address");

  push_pop_c: cover property (isPush ##[1:12] isPop);
  flush_c: cover property (state_q == rs_exec_pkg::ST_FLUSH);
  tbl_run_c: cover property (tblWriteBusy_q [*8]);

endmodule

`default_nettype wire

/* src/rs_exec_pkg.sv */
// Constants, opcodes and carrier types for the return-stack execution control block.
// Assumes one core clock, with four clocks making one instruction cycle.
// Function
// - Read-modify-write of a port register takes the operand from pin levels.
// - A write to the timer-zero count clears its prescaler when assigned.
// - A changed program counter or true test on a one-word instruction adds one no-operation cycle.
// - A lone second word of a two-word instruction executes as no-operation.
// - A launched table write cycle runs on until the memory ends it.
// - Stack-discard drops the top entry, exposes the one below, flags untouched.
package rs_exec_pkg;

  // ---------------------------------------------------------------
  // Instruction cycle phases
  // ---------------------------------------------------------------
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  // ---------------------------------------------------------------
  // Opcodes and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] OP_STACK_DISCARD = 16'h0006;
  localparam logic [15:0] OP_STACK_PUSH = 16'h0005;
  localparam logic [13:0] OP_TBLWT_TOP = 14'h0003;
  localparam logic [3:0] PREFIX_SECOND_WORD = 4'hF;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [20:0] RST_STACK_TOP = 21'h000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FLUSH = 2'b01,
    ST_OPERAND = 2'b10
  } exec_state_t;

  typedef struct packed {
    logic selPins;
    logic [7:0] operand;
  } rmw_req_t;

endpackage

/* testbench/return_stack_exec_tb.sv */
// Self-checking bench for the return-stack execution control block.
// Assumes the design's own assertions guard timing; bench drives every port.
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) \
  begin \
    samplesChecked++; \
    if ((a) !== (e)) \
    begin \
      nErrors++; \
      $display("Error t=%0t got %0h exp %0h", $time, a, e); \
    end \
  end

module return_stack_exec_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instrWord = 16'h0000;
  logic [20:0] pcPlus2 = 21'h000000;
  logic pcChange = 1'b0;
  logic condTrue = 1'b0;
  logic aluStatusWe = 1'b0;
  logic timerPrescalerAssigned = 1'b0;
  logic tblWriteLaunch = 1'b0;
  logic memWriteDone = 1'b0;
  logic [39:0] portPins = 40'h00000000A5;
  logic [1:0] qPhase_q;
  logic execNop_q;
  logic consumedWord_q;
  logic statusWe_q;
  logic prescalerClr_q;
  rs_exec_pkg::rmw_req_t rmw_q;
  logic tblWriteBusy_q;
  logic [20:0] returnStackTop_q;
  logic [4:0] stackPtr_q;
  int nErrors = 0;
  int samplesChecked = 0;
  logic sawWe;
  logic sawClr;

  return_stack_exec return_stack_exec_inst (
    .clk(clk), .rst(rst), .instrWord(instrWord), .pcPlus2(pcPlus2),
    .pcChange(pcChange), .condTrue(condTrue), .aluStatusWe(aluStatusWe),
    .timerPrescalerAssigned(timerPrescalerAssigned), .tblWriteLaunch(tblWriteLaunch),
    .memWriteDone(memWriteDone), .portPins(portPins), .qPhase_q(qPhase_q),
    .execNop_q(execNop_q), .consumedWord_q(consumedWord_q), .statusWe_q(statusWe_q),
    .prescalerClr_q(prescalerClr_q), .rmw_q(rmw_q), .tblWriteBusy_q(tblWriteBusy_q),
    .returnStackTop_q(returnStackTop_q), .stackPtr_q(stackPtr_q)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Hands the next word over at the Q4 edge; ctl and the flag pulses seen
  // belong to the word already executing, which that edge retires
  task automatic issue(input logic [15:0] w, input logic [4:0] ctl);
    int k;
    k = 0;
    while (qPhase_q !== 2'h3 && k < 8)
    begin
      edges(1);
      k++;
    end
    instrWord = w;
    {pcChange, condTrue, aluStatusWe, timerPrescalerAssigned, tblWriteLaunch} = ctl;
    edges(1);
    instrWord = 16'h0000;
    {pcChange, condTrue, aluStatusWe, timerPrescalerAssigned, tblWriteLaunch} = 5'h00;
    sawWe = statusWe_q;
    sawClr = prescalerClr_q;
    edges(1);
    sawWe = sawWe | statusWe_q;
    sawClr = sawClr | prescalerClr_q;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic stack_ops;
    pcPlus2 = 21'h01433;
    issue(rs_exec_pkg::OP_STACK_PUSH, 5'h00);
    edges(2);
    `CHK(returnStackTop_q, 21'h01433)
    `CHK(stackPtr_q, 5'h01)
    pcPlus2 = 21'h0345A;
    issue(rs_exec_pkg::OP_STACK_PUSH, 5'h04);
    `CHK(sawWe, 1'b0)
    edges(2);
    `CHK(returnStackTop_q, 21'h0345A)
    `CHK(stackPtr_q, 5'h02)
    issue(rs_exec_pkg::OP_STACK_DISCARD, 5'h04);
    `CHK(sawWe, 1'b0)
    edges(2);
    `CHK(returnStackTop_q, 21'h01433)
    `CHK(stackPtr_q, 5'h01)
    issue(16'h0F05, 5'h04);
    `CHK(sawWe, 1'b0)
    // Plain literal add with flag write as the positive control
    issue(16'h0000, 5'h04);
    `CHK(sawWe, 1'b1)
  endtask

  // A push right after a flow change must be squashed
  task automatic flush_cycles;
    issue(16'hEF10, 5'h00);
    issue(16'hF000, 5'h10);
    `CHK(consumedWord_q, 1'b1)
    issue(16'hB000, 5'h00);
    pcPlus2 = 21'h00777;
    issue(rs_exec_pkg::OP_STACK_PUSH, 5'h08);
    `CHK(execNop_q, 1'b1)
    edges(2);
    `CHK(stackPtr_q, 5'h01)
    issue(16'h0000, 5'h00);
    issue(16'h0F01, 5'h10);
    `CHK(execNop_q, 1'b1)
    issue(16'hF123, 5'h00);
    `CHK(execNop_q, 1'b1)
    `CHK(consumedWord_q, 1'b0)
  endtask

  task automatic side_effects;
    issue(16'h6ED6, 5'h00);
    issue(16'h6ED6, 5'h02);
    `CHK(sawClr, 1'b1)
    issue(16'h50D6, 5'h00);
    `CHK(sawClr, 1'b0)
    issue(16'h5280, 5'h02);
    `CHK(sawClr, 1'b0)
    // Operand is taken at the Q2 edge of the write-back
    edges(1);
    `CHK(rmw_q.selPins, 1'b1)
    `CHK(rmw_q.operand, 8'hA5)
  endtask

  task automatic table_write;
    issue(16'h000C, 5'h00);
    issue(16'h0000, 5'h01);
    `CHK(tblWriteBusy_q, 1'b1)
    issue(16'h0000, 5'h10);
    issue(16'h0000, 5'h00);
    issue(16'h0000, 5'h00);
    `CHK(tblWriteBusy_q, 1'b1)
    memWriteDone = 1'b1;
    edges(1);
    memWriteDone = 1'b0;
    edges(1);
    `CHK(tblWriteBusy_q, 1'b0)
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    edges(12);
    rst = 1'b0;
    `CHK(stackPtr_q, 5'h00)
    `CHK(qPhase_q, 2'h0)
    stack_ops();
    flush_cycles();
    side_effects();
    table_write();
    end_sim();
  end

  initial
  begin
    #200000;
    nErrors++;
    end_sim();
  end
endmodule

`default_nettype wire
